// ===== include/acm_pkg.sv
// constants and types for the calibration mode and configuration decoder
package acm_pkg;
    localparam int WORD_W = 24;
    localparam int N_CH = 3;
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_SELF = 3'h1;
    localparam logic [2:0] MODE_SYS_ZERO = 3'h2;
    localparam logic [2:0] MODE_SYS_FULL = 3'h3;
    localparam logic [2:0] MODE_SYS_OFFS = 3'h4;
    localparam logic [2:0] MODE_BACKGND = 3'h5;
    localparam logic [2:0] MODE_RW_ZERO = 3'h6;
    localparam logic [2:0] MODE_RW_FULL = 3'h7;
    // config word field positions
    localparam int MODE_LSB = 21;
    localparam int GAIN_LSB = 18;
    localparam int CHAN_LSB = 16;
    localparam int WL_BIT = 15;
    localparam int EXC_BIT = 14;
    localparam int BURN_BIT = 13;
    localparam logic [23:0] CFG_RESET = 24'h000000;
    localparam logic [23:0] ZERO_COEF_RESET = 24'h000000;
    localparam logic [23:0] FULL_COEF_RESET = 24'h800000;
    localparam logic [4:0] BITS_PER_WORD = 5'h18;
    localparam logic [2:0] BG_RATIO = 3'h6;
    // measurement time per calibration step, in cycles
    localparam logic [7:0] CAL_CYCLES = 8'h20;
    // axi register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h04;
    localparam logic [7:0] OFS_CFG = 8'h08;
    localparam logic [7:0] OFS_MEAS = 8'h0c;
    localparam logic [7:0] OFS_STATE = 8'h10;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ZERO = 2'b01,
        ST_FULL = 2'b11,
        ST_DONE = 2'b10
    } acm_state_type;
endpackage

// ===== rtl/acm_top.sv
// calibration mode and front-end configuration decoder with serial port and axi-lite
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module acm_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic transmit_frame_n,
    input wire logic serial_clk,
    input wire logic serial_din,
    input wire logic register_select,
    input wire logic [23:0] result_word,
    input wire logic result_valid,
    output logic serial_dout,
    output logic result_ready_n,
    output logic [7:0] gain_factor,
    output logic [2:0] input_route,
    output logic excitation_current_en,
    output logic burnout_current_en,
    output logic word_length_sel,
    output logic irq
);
    import acm_pkg::*;

    logic [23:0] cfg_r;
    logic [23:0] zero_coef_r [N_CH];
    logic [23:0] full_coef_r [N_CH];
    logic [23:0] shift_r;
    logic [23:0] tx_r;
    logic [4:0] bit_cnt_r;
    logic frame_d_r;
    logic sclk_d_r;
    logic [2:0] bg_cnt_r;
    logic [7:0] cal_cnt_r;
    acm_state_type state_r;
    logic [2:0] sts_r;
    logic [2:0] mask_r;
    logic cal_done_p;
    logic cfg_wr_p;
    logic coef_wr_p;
    logic bg_update_p;
    logic word_drop_p;
    logic sw_cfg_wr;
    logic [23:0] sw_cfg_data;

    wire [2:0] mode_sel = cfg_r[MODE_LSB +: 3];
    wire [1:0] chan = cfg_r[CHAN_LSB +: 2];
    wire [1:0] ch_idx = (chan == 2'h3) ? 2'h2 : chan;
    wire sclk_rise = serial_clk & ~sclk_d_r;
    wire frame_on = ~transmit_frame_n;
    wire frame_end = frame_d_r & transmit_frame_n;
    wire full_word = (bit_cnt_r == BITS_PER_WORD);

    // serial receive: bits past the 24th are ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shift_r <= '0;
            bit_cnt_r <= '0;
            frame_d_r <= 1'b0;
            sclk_d_r <= 1'b0;
        end else begin
            frame_d_r <= frame_on;
            sclk_d_r <= serial_clk;
            if (!frame_on) begin
                bit_cnt_r <= '0;
            end else if (sclk_rise && !full_word) begin
                shift_r <= {shift_r[22:0], serial_din};
                bit_cnt_r <= bit_cnt_r + 5'h1;
            end
        end
    end

    // commit only on frame end with all 24 bits; short frames dropped
    assign cfg_wr_p = frame_end && full_word && !register_select;
    assign coef_wr_p = frame_end && full_word && register_select &&
        (mode_sel == MODE_RW_ZERO || mode_sel == MODE_RW_FULL);
    assign word_drop_p = frame_end && !full_word && (bit_cnt_r != 5'h0);

    // serial transmit: config when select is low; when high, coefficient in modes 110/111, else result
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_r <= '0;
            serial_dout <= 1'b0;
        end else if (!frame_on) begin
            if (!register_select) begin
                tx_r <= cfg_r;
            end else if (mode_sel == MODE_RW_ZERO) begin
                tx_r <= zero_coef_r[ch_idx];
            end else if (mode_sel == MODE_RW_FULL) begin
                tx_r <= full_coef_r[ch_idx];
            end else begin
                tx_r <= result_word;
            end
            serial_dout <= 1'b0;
        end else if (sclk_rise && !full_word) begin
            serial_dout <= tx_r[23];
            tx_r <= {tx_r[22:0], 1'b0};
        end
    end

    // calibration sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= ST_IDLE;
            cal_cnt_r <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    cal_cnt_r <= '0;
                    if (mode_sel == MODE_SELF || mode_sel == MODE_SYS_ZERO ||
                        mode_sel == MODE_SYS_OFFS) begin
                        state_r <= ST_ZERO;
                    end else if (mode_sel == MODE_SYS_FULL) begin
                        state_r <= ST_FULL;
                    end
                end
                ST_ZERO: begin
                    cal_cnt_r <= cal_cnt_r + 8'h1;
                    if (cal_cnt_r == CAL_CYCLES - 8'h1) begin
                        cal_cnt_r <= '0;
                        // system zero step stops here; others also do full scale
                        state_r <= (mode_sel == MODE_SYS_ZERO) ? ST_DONE : ST_FULL;
                    end
                end
                ST_FULL: begin
                    cal_cnt_r <= cal_cnt_r + 8'h1;
                    if (cal_cnt_r == CAL_CYCLES - 8'h1) begin
                        state_r <= ST_DONE;
                    end
                end
                ST_DONE: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end
    assign cal_done_p = (state_r == ST_DONE);

    // background: one word out of every six reaches the host
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bg_cnt_r <= '0;
        end else if (mode_sel != MODE_BACKGND) begin
            bg_cnt_r <= '0;
        end else if (result_valid) begin
            bg_cnt_r <= (bg_cnt_r == BG_RATIO - 3'h1) ? 3'h0 : bg_cnt_r + 3'h1;
        end
    end
    assign bg_update_p = (mode_sel == MODE_BACKGND) && result_valid &&
        (bg_cnt_r != BG_RATIO - 3'h1);

    // configuration word; every calibration falls back to normal when done
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r <= CFG_RESET;
        end else if (cfg_wr_p) begin
            cfg_r <= shift_r;
        end else if (sw_cfg_wr) begin
            cfg_r <= sw_cfg_data;
        end else if (cal_done_p) begin
            cfg_r[MODE_LSB +: 3] <= MODE_NORMAL;
        end
    end

    // coefficient store; calibration and background measure into it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < N_CH; i++) begin
                zero_coef_r[i] <= ZERO_COEF_RESET;
                full_coef_r[i] <= FULL_COEF_RESET;
            end
        end else if (coef_wr_p) begin
            if (mode_sel == MODE_RW_ZERO) begin
                zero_coef_r[ch_idx] <= shift_r;
            end else begin
                full_coef_r[ch_idx] <= shift_r;
            end
        end else if (bg_update_p) begin
            // shorted and reference slots alternate between words
            if (bg_cnt_r[0]) begin
                full_coef_r[ch_idx] <= result_word;
            end else begin
                zero_coef_r[ch_idx] <= result_word;
            end
        end else if (state_r == ST_ZERO && cal_cnt_r == CAL_CYCLES - 8'h1) begin
            zero_coef_r[ch_idx] <= result_word;
        end else if (state_r == ST_FULL && cal_cnt_r == CAL_CYCLES - 8'h1) begin
            full_coef_r[ch_idx] <= result_word;
        end
    end

    // ready goes low for one cycle on calibration end or a kept result
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_ready_n <= 1'b1;
        end else begin
            result_ready_n <= ~(cal_done_p || (result_valid && state_r == ST_IDLE &&
                (mode_sel != MODE_BACKGND || bg_cnt_r == BG_RATIO - 3'h1)));
        end
    end

    // front-end decode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gain_factor <= 8'h01;
            input_route <= 3'h1;
            excitation_current_en <= 1'b0;
            burnout_current_en <= 1'b0;
            word_length_sel <= 1'b0;
        end else begin
            gain_factor <= 8'h01 << cfg_r[GAIN_LSB +: 3];
            input_route <= (chan == 2'h0) ? 3'h1 : (chan == 2'h1) ? 3'h2 :
                (chan == 2'h2) ? 3'h4 : 3'h0;
            excitation_current_en <= cfg_r[EXC_BIT];
            burnout_current_en <= cfg_r[BURN_BIT];
            word_length_sel <= cfg_r[WL_BIT];
        end
    end

    // axi-lite slave
    logic aw_hold_r;
    logic w_hold_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire have_aw = aw_hold_r || aw_take;
    wire have_w = w_hold_r || w_take;
    wire [7:0] wa = aw_take ? s_axi_awaddr : aw_addr_r;
    wire [31:0] wd = w_take ? s_axi_wdata : w_data_r;
    wire wr_go = have_aw && have_w && !s_axi_bvalid;
    assign sw_cfg_wr = wr_go && (wa == OFS_CFG) && (&s_axi_wstrb[2:0] || w_hold_r);
    assign sw_cfg_data = wd[23:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            s_axi_awready <= !have_aw && !s_axi_bvalid && !s_axi_awready;
            s_axi_wready <= !have_w && !s_axi_bvalid && !s_axi_wready;
            if (aw_take) begin
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_r <= s_axi_wdata;
            end
            if (wr_go) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wa == OFS_STATUS || wa == OFS_MASK || wa == OFS_CFG) ?
                    2'b00 : 2'b10;
            end else begin
                aw_hold_r <= have_aw;
                w_hold_r <= have_w;
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // sticky events: done, short frame dropped, background update; set beats clear
    wire [2:0] ev = {bg_update_p, word_drop_p, cal_done_p};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sts_r <= '0;
            mask_r <= '0;
            irq <= 1'b0;
        end else begin
            if (wr_go && wa == OFS_STATUS) begin
                sts_r <= (sts_r & ~wd[2:0]) | ev;
            end else begin
                sts_r <= sts_r | ev;
            end
            if (wr_go && wa == OFS_MASK) begin
                mask_r <= wd[2:0];
            end
            irq <= |(sts_r & mask_r);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                case (s_axi_araddr)
                    OFS_STATUS: s_axi_rdata <= {29'h0, sts_r};
                    OFS_MASK: s_axi_rdata <= {29'h0, mask_r};
                    OFS_CFG: s_axi_rdata <= {8'h0, cfg_r};
                    OFS_MEAS: s_axi_rdata <= {8'h0, zero_coef_r[ch_idx]};
                    OFS_STATE: s_axi_rdata <= {27'h0, bg_cnt_r, state_r};
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // acm_top
`default_nettype wire

// ===== dv/acm_chk.sv
// port-level assertions for the calibration mode decoder
`timescale 1ns/1ps
`default_nettype none
module acm_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic transmit_frame_n,
    input wire logic serial_dout,
    input wire logic result_ready_n,
    input wire logic [7:0] gain_factor,
    input wire logic [2:0] input_route,
    input wire logic excitation_current_en,
    input wire logic burnout_current_en,
    input wire logic word_length_sel
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence idle_s; transmit_frame_n [*2]; endsequence
    sequence pulse_s; !result_ready_n ##1 result_ready_n; endsequence
    rst_vals_a: assert property ($rose(aresetn) |-> gain_factor == 8'h01
        && input_route == 3'h1 && !excitation_current_en && !burnout_current_en
        && !word_length_sel && result_ready_n) else $error("bad values after reset");
    ready_pulse_a: assert property ($fell(result_ready_n) |-> pulse_s)
        else $error("ready pulse not one cycle");
    gain_pow2_a: assert property ($onehot(gain_factor))
        else $error("gain not a power of two");
    route_one_a: assert property ($onehot0(input_route))
        else $error("more than one input routed");
    dout_idle_a: assert property (idle_s |-> !serial_dout)
        else $error("data out active outside frame");
    cfg_frame_a: assert property (!transmit_frame_n |=> $stable(gain_factor))
        else $error("config changed inside frame");
    bresp_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    rresp_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
endmodule // acm_chk
bind acm_top acm_chk chk_u (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
    .s_axi_rready, .transmit_frame_n, .serial_dout, .result_ready_n, .gain_factor,
    .input_route, .excitation_current_en, .burnout_current_en, .word_length_sel);
`default_nettype wire

// ===== dv/acm_host.sv
// serial-port host model that frames words into the decoder
`timescale 1ns/1ps
`default_nettype none
module acm_host (
    input wire logic aclk,
    input wire logic serial_dout,
    output logic serial_clk,
    output logic serial_din,
    output logic transmit_frame_n,
    output logic register_select
);
    initial begin
        serial_clk = 1'b0;
        serial_din = 1'b0;
        transmit_frame_n = 1'b1;
        register_select = 1'b0;
    end
    // three aclk per phase: the port needs one to see each level
    task automatic xfer(input logic rs, input logic [23:0] w, input int n,
        output logic [23:0] r);
        r = 24'h000000;
        register_select <= rs;
        // select settles one edge before the frame, so the snapshot sees it
        @(posedge aclk);
        transmit_frame_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_din <= (i < 24) ? w[23 - i] : 1'b1;
            repeat (3) @(posedge aclk);
            serial_clk <= 1'b1;
            repeat (3) @(posedge aclk);
            // each rise launches the next bit, so it is read in the high phase
            if (i < 24) r[23 - i] = serial_dout;
            serial_clk <= 1'b0;
        end
        repeat (2) @(posedge aclk);
        transmit_frame_n <= 1'b1;
        // released line must not keep its last bit
        serial_din <= ~serial_din;
        repeat (4) @(posedge aclk);
    endtask
endmodule // acm_host
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench for the calibration mode decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
    $display("CHECK FAILED at %0t: got %h want %h", $time, a, b); end end
`define TO(c) if ((c) >= 300) begin bad_count++; \
    $display("CHECK FAILED at %0t: timeout", $time); end_of_test; end
module tb_top;
    import acm_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, result_valid = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, gain_factor;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [23:0] result_word = 24'h0, w, r, ez;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, s;
    logic transmit_frame_n, serial_clk, serial_din, register_select, serial_dout;
    logic [2:0] input_route;
    logic [2:0] cal_m [3] = '{MODE_SYS_ZERO, MODE_SYS_FULL, MODE_SYS_OFFS};
    logic result_ready_n, excitation_current_en, burnout_current_en, word_length_sel, irq;
    int bad_count = 0, n_tests = 0, t, k, p;
    always #20 aclk = ~aclk;
    acm_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .transmit_frame_n,
        .serial_clk, .serial_din, .register_select, .result_word, .result_valid,
        .serial_dout, .result_ready_n, .gain_factor, .input_route, .excitation_current_en,
        .burnout_current_en, .word_length_sel, .irq);
    acm_host host_u (.aclk, .serial_dout, .serial_clk, .serial_din, .transmit_frame_n,
        .register_select);
    task end_of_test;
        $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task axi_wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, wd;
        aw = 1'b1;
        wd = 1'b1;
        t = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while ((aw || wd) && t < 300) begin
            @(posedge aclk);
            t++;
            if (aw && s_axi_awready) begin aw = 1'b0; s_axi_awvalid <= 1'b0; end
            if (wd && s_axi_wready) begin wd = 1'b0; s_axi_wvalid <= 1'b0; end
        end
        do begin @(posedge aclk); t++; end while (!s_axi_bvalid && t < 300);
        s = s_axi_bresp;
        s_axi_bready <= 1'b0;
        `TO(t)
    endtask
    task axi_rd(input logic [7:0] a);
        t = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin @(posedge aclk); t++; end while (!s_axi_arready && t < 300);
        s_axi_arvalid <= 1'b0;
        do begin @(posedge aclk); t++; end while (!s_axi_rvalid && t < 300);
        d = s_axi_rdata;
        s = s_axi_rresp;
        s_axi_rready <= 1'b0;
        `TO(t)
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(OFS_CFG);
        `CHK(d, 32'h0)
        for (k = 0; k < 8; k++) begin
            w = 24'(k << GAIN_LSB | k % 3 << CHAN_LSB | k << BURN_BIT);
            host_u.xfer(1'b0, w, 24, r);
            `CHK(gain_factor, 8'(1 << k))
            `CHK(input_route, 3'(1 << (k % 3)))
            `CHK({word_length_sel, excitation_current_en, burnout_current_en}, 3'(k))
            host_u.xfer(1'b0, w, 24, r);
            `CHK(r, w)
        end
        // interrupt: masked first, then unmasked, then cleared
        axi_wr(OFS_MASK, 32'h0);
        host_u.xfer(1'b0, 24'h000000, 12, r);
        `CHK(gain_factor, 8'h80)
        `CHK(irq, 1'b0)
        axi_wr(OFS_MASK, 32'h7);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b1)
        axi_wr(OFS_STATUS, 32'h7);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b0)
        host_u.xfer(1'b0, 24'h0c0000, 26, r);
        `CHK(gain_factor, 8'h08)
        `CHK(input_route, 3'h1)
        axi_rd(8'h40);
        `CHK(s, 2'h2)
        axi_wr(8'h40, 32'h1);
        `CHK(s, 2'h2)
        axi_wr(OFS_CFG, {8'h00, MODE_RW_ZERO, 5'h01, 16'h0});
        host_u.xfer(1'b1, 24'h123456, 24, r);
        host_u.xfer(1'b1, 24'hffffff, 20, r);
        axi_rd(OFS_MEAS);
        `CHK(d[23:0], 24'h123456)
        host_u.xfer(1'b1, 24'h123456, 24, r);
        `CHK(r, 24'h123456)
        axi_wr(OFS_CFG, {8'h00, MODE_RW_FULL, 5'h01, 16'h0});
        host_u.xfer(1'b1, 24'h654321, 24, r);
        `CHK(r, FULL_COEF_RESET)
        host_u.xfer(1'b1, 24'h654321, 24, r);
        `CHK(r, 24'h654321)
        ez = 24'h0;
        for (k = 0; k < 3; k++) begin
            w = 24'h00a000 + 24'(k);
            result_word <= w;
            if (cal_m[k] != MODE_SYS_FULL) ez = w;
            axi_wr(OFS_CFG, {8'h00, cal_m[k], 5'h02, 16'h0});
            t = 0;
            do begin @(posedge aclk); t++; end while (result_ready_n && t < 300);
            `TO(t)
            axi_rd(OFS_CFG);
            `CHK(d[23:21], MODE_NORMAL)
            axi_rd(OFS_MEAS);
            `CHK(d[23:0], ez)
        end
        axi_wr(OFS_CFG, {8'h00, MODE_RW_FULL, 5'h02, 16'h0});
        host_u.xfer(1'b1, 24'h00a002, 24, r);
        `CHK(r, 24'h00a002)
        result_word <= 24'h00beef;
        axi_wr(OFS_CFG, {8'h00, MODE_BACKGND, 5'h02, 16'h0});
        p = 0;
        for (k = 0; k < 12; k++) begin
            result_valid <= 1'b1;
            @(posedge aclk);
            result_valid <= 1'b0;
            repeat (4) begin @(posedge aclk); if (!result_ready_n) p++; end
        end
        `CHK(p, 2)
        axi_rd(OFS_MEAS);
        `CHK(d[23:0], 24'h00beef)
        axi_wr(OFS_CFG, 32'h0);
        host_u.xfer(1'b1, 24'h000000, 24, r);
        `CHK(r, 24'h00beef)
        end_of_test;
    end
endmodule // tb_top
`default_nettype wire
